// ---- rtl/sync_burst_sram_pkg.sv ----
/*
  Shared constants of the flow-through synchronous burst SRAM access block:
  array geometry, byte lane layout and values after reset.
  Assumes nothing of its surroundings.
*/
package sync_burst_sram_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } access_e;

endpackage : sync_burst_sram_pkg

// ---- rtl/sync_burst_sram_access.sv ----
/*
  Access logic of a flow-through synchronous burst SRAM, 128K x 36, with
  a common data bus split into input, output and output enable.
  Assumes a single clock; all synchronous pins are already in clk_sys's
  domain (they are sampled by the registers on every rising edge, as on
  the real part). Output enable and sleep are asynchronous and reach the
  data bus enable through gates only.
*/
// Behaviour
// - The array holds 128K words of 36 bits behind one shared data bus.
// - A 2-bit burst counter is cleared on the strobe and, offset from the stored start bits, supplies the rest.
// - All synchronous inputs are captured in registers on the rising clock edge.
// - Burst order high selects interleaved order and low selects linear order.
// - A burst begins only when one of the two address strobes is asserted.
// - With the controller strobe, or the processor strobe and primary select low, the edge registers address and chip enables.
// - After the first access the following addresses are generated internally.
// - Output enable and sleep act asynchronously and are never clocked.
// - A four-beat burst completes in a two, one, one, one clock cadence.
// - A registered write completes with internal timing and no external pulse.
// - The two low address bits feed the counter; upper bits stay fixed.
// - A sampled low global write writes all four bytes.
// - With global write high and the byte qualifier low only lanes whose select is low are written.
// - The counter advances on an edge only when advance is sampled low.
`timescale 1ns/1ps
module sync_burst_sram_access
  import sync_burst_sram_pkg::*;
#(
  parameter int DEPTH = 131072
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_b,
  input wire logic controller_addr_strobe_b,
  input wire logic burst_advance_b,
  input wire logic chip_sel_primary_b,
  input wire logic depth_sel_high,
  input wire logic depth_sel_low_b,
  input wire logic [LANES-1:0] byte_lane_write_sel_b,
  input wire logic byte_write_qualifier_b,
  input wire logic all_bytes_write_b,
  input wire logic burst_mode,
  input wire logic out_enable_b,
  input wire logic sleep_request,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);

  // Burst and read state of the block in one record; array and output flops stand apart
  typedef struct packed {
    access_e st;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] cnt;
    logic [LANES-1:0] wr_lanes;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic first_beat;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;
  logic [DATA_W-1:0] mem [DEPTH];
  logic strobe;
  logic selected;
  logic proc_ok;
  logic [LANES-1:0] lanes_now;
  logic [ADDR_W-1:0] cur_addr;
  logic [BURST_W-1:0] beat_cnt;
  logic [ADDR_W-1:0] new_addr;
  logic do_write;
  logic do_read;
  logic oe_q_ff;

  // Burst address offset: interleaved XORs, linear adds, both wrap in 2 bits
  function automatic logic [BURST_W-1:0] burst_offs(
    input logic mode,
    input logic [BURST_W-1:0] st,
    input logic [BURST_W-1:0] n
  );
    if (mode)
      return st ^ n;
    else
      return BURST_W'(st + n);
  endfunction : burst_offs

  // Byte lane enables: global write beats the qualified lane selects
  function automatic logic [LANES-1:0] lane_enables(
    input logic gw_b,
    input logic bwe_b,
    input logic [LANES-1:0] sel_b
  );
    if (!gw_b)
      return {LANES{1'b1}};
    else if (!bwe_b)
      return ~sel_b;
    else
      return '0;
  endfunction : lane_enables

  // Strobe decode; the processor strobe is ignored while the primary select is high
  assign proc_ok = !processor_addr_strobe_b && !chip_sel_primary_b;
  assign strobe = proc_ok || !controller_addr_strobe_b;
  assign selected = !chip_sel_primary_b && depth_sel_high && !depth_sel_low_b;
  assign lanes_now = lane_enables(all_bytes_write_b, byte_write_qualifier_b,
                                  byte_lane_write_sel_b);
  // Beat count: the first beat keeps the start, later beats step before the access,
  // so a held advance repeats the same word instead of lagging one beat behind
  assign beat_cnt = (!cur_ff.first_beat && !burst_advance_b) ?
                    BURST_W'(cur_ff.cnt + 2'h1) : cur_ff.cnt;
  assign cur_addr = {cur_ff.base[ADDR_W-1:BURST_W],
                     burst_offs(burst_mode, cur_ff.start, beat_cnt)};
  assign new_addr = addr;

  // Next state: load on strobe, otherwise step the counter on advance
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.rd_valid = 1'b0;
    nxt_ff.first_beat = 1'b0;
    do_write = 1'b0;
    do_read = 1'b0;
    if (strobe)
    begin
      // Processor strobe start is always a read; writes follow on a later beat
      nxt_ff.base = new_addr;
      nxt_ff.start = new_addr[BURST_W-1:0];
      nxt_ff.cnt = BURST_RST;
      nxt_ff.first_beat = 1'b1;
      if (!selected)
        nxt_ff.st = ST_IDLE;
      else if (!proc_ok && (|lanes_now))
      begin
        nxt_ff.st = ST_WRITE;
        nxt_ff.wr_lanes = lanes_now;
      end
      else
        nxt_ff.st = ST_READ;
    end
    else
    begin
      case (cur_ff.st)
        ST_IDLE:
        begin
          nxt_ff.st = ST_IDLE;
        end
        ST_READ, ST_WRITE:
        begin
          // Lanes given on the data beat decide write or read for this beat
          nxt_ff.cnt = beat_cnt;
          if (|lanes_now)
          begin
            nxt_ff.st = ST_WRITE;
            nxt_ff.wr_lanes = lanes_now;
            do_write = 1'b1;
          end
          else
          begin
            nxt_ff.st = ST_READ;
            do_read = 1'b1;
          end
        end
        default:
        begin
          nxt_ff.st = ST_IDLE;
        end
      endcase
    end
    if (do_read)
    begin
      nxt_ff.rd_data = mem[cur_addr[$clog2(DEPTH)-1:0]];
      nxt_ff.rd_valid = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cur_ff.st <= ST_IDLE;
      cur_ff.base <= ADDR_RST;
      cur_ff.start <= BURST_RST;
      cur_ff.cnt <= BURST_RST;
      cur_ff.wr_lanes <= '0;
      cur_ff.rd_data <= DATA_RST;
      cur_ff.rd_valid <= 1'b0;
      cur_ff.first_beat <= 1'b0;
    end
    else
      cur_ff <= nxt_ff;
  end

  // Self-timed array write: per-lane, at the same clock edge that samples the data
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < LANES; i++)
      if (do_write && lanes_now[i])
        mem[cur_addr[$clog2(DEPTH)-1:0]][i*LANE_W +: LANE_W] <=
          dq_in[i*LANE_W +: LANE_W];
  end

  // Read data and its valid flag are registered here; output enable never passes
  // through a flop and is gated onto the port without the clock.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      dq_out <= DATA_RST;
      oe_q_ff <= 1'b0;
    end
    else
    begin
      if (nxt_ff.rd_valid)
        dq_out <= nxt_ff.rd_data;
      oe_q_ff <= nxt_ff.rd_valid;
    end
  end

  // Sleep and output enable act without the clock; sleep is expected tied low
  assign dq_oe = oe_q_ff && !out_enable_b && !sleep_request;

  // Assertions
  sequence strobe_seen_s;
    strobe && selected;
  endsequence

  sequence count_reset_s;
    cur_ff.cnt == BURST_RST;
  endsequence

  sequence full_write_s;
    do_write && lanes_now == 4'hf;
  endsequence

  strobe_loads_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    strobe |=> cur_ff.base == $past(addr))
    else $error("Address not registered on strobe");

  low_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    strobe |=> cur_ff.start == $past(addr[1:0]))
    else $error("Burst start not loaded");

  count_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    strobe_seen_s |=> count_reset_s)
    else $error("Burst counter not cleared");

  hold_count_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!strobe && burst_advance_b) |=> $stable(cur_ff.cnt))
    else $error("Counter moved without advance");

  step_count_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!strobe && !burst_advance_b && cur_ff.st != ST_IDLE && !cur_ff.first_beat)
    |=> cur_ff.cnt == 2'($past(cur_ff.cnt) + 2'h1))
    else $error("Counter did not step");

  no_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!strobe && cur_ff.st == ST_IDLE) |=> cur_ff.st == ST_IDLE)
    else $error("Access began without a strobe");

  oe_async_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    out_enable_b |-> !dq_oe)
    else $error("Bus driven with output enable high");

  global_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !all_bytes_write_b |-> lanes_now == 4'hf)
    else $error("Global write missed a lane");

  byte_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (all_bytes_write_b && !byte_write_qualifier_b) |-> lanes_now == ~byte_lane_write_sel_b)
    else $error("Byte lanes wrong");

  cadence_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (strobe_seen_s ##1 (do_read && !strobe)) |=> oe_q_ff)
    else $error("Read data late");

  interleave_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (burst_mode && cur_ff.st != ST_IDLE) |->
      cur_addr[1:0] == (cur_ff.start ^ beat_cnt))
    else $error("Interleaved order wrong");

  data_out_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    nxt_ff.rd_valid |=> dq_out == $past(nxt_ff.rd_data))
    else $error("Read data not presented");

  proc_gated_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!processor_addr_strobe_b && chip_sel_primary_b && controller_addr_strobe_b) |-> !strobe)
    else $error("Processor strobe taken while primary select high");

  desel_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (strobe && !selected) |=> cur_ff.st == ST_IDLE)
    else $error("Deselected strobe started an access");

  write_lands_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    full_write_s |=> mem[$past(cur_addr[$clog2(DEPTH)-1:0])] == $past(dq_in))
    else $error("Write data did not reach the array");

  read_beat_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cur_ff.st != ST_IDLE && !strobe && lanes_now == 4'h0) |=> oe_q_ff)
    else $error("Read beat gave no data");

  upper_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!strobe && cur_ff.st != ST_IDLE) |=> $stable(cur_ff.base))
    else $error("Upper address moved inside a burst");

endmodule : sync_burst_sram_access

// ---- test/host_model.sv ----
/*
  Cache controller model that drives every input of the access block except clock and reset.
  Assumes clk_sys from the bench; tasks are called just after a rising edge.
*/
`timescale 1ns/1ps
module host_model
  import sync_burst_sram_pkg::*;
(
  input wire logic clk_sys,
  output logic [ADDR_W-1:0] addr,
  output logic processor_addr_strobe_b,
  output logic controller_addr_strobe_b,
  output logic burst_advance_b,
  output logic chip_sel_primary_b,
  output logic depth_sel_high,
  output logic depth_sel_low_b,
  output logic [LANES-1:0] byte_lane_write_sel_b,
  output logic byte_write_qualifier_b,
  output logic all_bytes_write_b,
  output logic burst_mode,
  output logic out_enable_b,
  output logic sleep_request,
  output logic [DATA_W-1:0] dq_in
);
  // Idle pins: no strobe, device selected, sleep never used
  initial
  begin
    addr = '0;
    processor_addr_strobe_b = 1'b1;
    controller_addr_strobe_b = 1'b1;
    burst_advance_b = 1'b1;
    chip_sel_primary_b = 1'b0;
    depth_sel_high = 1'b1;
    depth_sel_low_b = 1'b0;
    byte_lane_write_sel_b = 4'hf;
    byte_write_qualifier_b = 1'b1;
    all_bytes_write_b = 1'b1;
    burst_mode = 1'b0;
    out_enable_b = 1'b0;
    sleep_request = 1'b0;
    dq_in = 36'h5a5a5a5a5;
  end

  // One strobe edge; address and select are scrambled once no longer sampled
  task automatic start(input logic ctl, input logic mode, input logic sel,
                       input logic [ADDR_W-1:0] a, input logic wr);
    processor_addr_strobe_b = ctl;
    controller_addr_strobe_b = !ctl;
    burst_mode = mode;
    depth_sel_high = sel;
    addr = a;
    all_bytes_write_b = !wr;
    byte_write_qualifier_b = 1'b1;
    @(posedge clk_sys);
    #1;
    processor_addr_strobe_b = 1'b1;
    controller_addr_strobe_b = 1'b1;
    addr = ~a;
    depth_sel_high = !sel;
  endtask : start

  // One beat; read beats toggle the idle data so a stale value cannot match
  task automatic beat(input logic adv_b, input logic gw_b, input logic bwe_b,
                      input logic [LANES-1:0] sel_b, input logic [DATA_W-1:0] d);
    burst_advance_b = adv_b;
    all_bytes_write_b = gw_b;
    byte_write_qualifier_b = bwe_b;
    byte_lane_write_sel_b = sel_b;
    dq_in = (gw_b && bwe_b) ? ~dq_in : d;
    @(posedge clk_sys);
    #1;
  endtask : beat
endmodule : host_model

// ---- test/sync_burst_sram_access_test.sv ----
/*
  Self-checking bench of the burst SRAM access block.
  Assumes the host model drives all pins but clock and reset; DEPTH is cut to 16 words.
*/
`timescale 1ns/1ps
module sync_burst_sram_access_test;
  import sync_burst_sram_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  wire [ADDR_W-1:0] addr;
  wire [DATA_W-1:0] dq_in, dq_out;
  wire [LANES-1:0] byte_lane_write_sel_b;
  wire processor_addr_strobe_b, controller_addr_strobe_b, burst_advance_b;
  wire chip_sel_primary_b, depth_sel_high, depth_sel_low_b, byte_write_qualifier_b;
  wire all_bytes_write_b, burst_mode, out_enable_b, sleep_request, dq_oe;
  logic [DATA_W-1:0] mem [16];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  host_model host_model_i (.clk_sys, .addr, .processor_addr_strobe_b,
    .controller_addr_strobe_b, .burst_advance_b, .chip_sel_primary_b, .depth_sel_high,
    .depth_sel_low_b, .byte_lane_write_sel_b, .byte_write_qualifier_b, .all_bytes_write_b,
    .burst_mode, .out_enable_b, .sleep_request, .dq_in);

  sync_burst_sram_access #(.DEPTH(16)) sync_burst_sram_access_i (.clk_sys, .rst_b, .addr,
    .processor_addr_strobe_b, .controller_addr_strobe_b, .burst_advance_b,
    .chip_sel_primary_b, .depth_sel_high, .depth_sel_low_b, .byte_lane_write_sel_b,
    .byte_write_qualifier_b, .all_bytes_write_b, .burst_mode, .out_enable_b,
    .sleep_request, .dq_in, .dq_out, .dq_oe);

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Hang guard; the whole run needs well under a hundred cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Linear write burst; the expected memory keeps only the enabled lanes
  task automatic t_write(input logic [ADDR_W-1:0] a, input int n, input logic gw_b,
                         input logic bwe_b, input logic [LANES-1:0] sel_b);
    logic [DATA_W-1:0] d;
    logic [ADDR_W-1:0] w;
    host_model_i.start(1'b1, 1'b0, 1'b1, a, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      d = 36'h123456789 ^ (36'h0f1e2d3c4 * (k + a));
      w = {a[ADDR_W-1:2], a[1:0] + k[1:0]};
      for (int i = 0; i < LANES; i++)
        if (!gw_b || (!bwe_b && !sel_b[i]))
          mem[w[3:0]][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      host_model_i.beat(1'b0, gw_b, bwe_b, sel_b, d);
      chk(dq_oe, 1'b0);
    end
  endtask : t_write

  // Five read beats: start, three steps, then the wrap back to start
  task automatic t_read(input logic mode, input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    host_model_i.start(1'b0, mode, 1'b1, a, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      s = mode ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
      host_model_i.beat(1'b0, 1'b1, 1'b1, 4'hf, '0);
      chk(dq_oe, 1'b1);
      chk(dq_out, mem[{a[3:2], s}]);
    end
  endtask : t_read

  // A processor strobe with the primary select high is ignored and the burst reads on;
  // a strobe while deselected must give no data
  task automatic t_desel();
    host_model_i.chip_sel_primary_b = 1'b1;
    host_model_i.start(1'b0, 1'b0, 1'b1, 17'h00004, 1'b0);
    chk(dq_oe, 1'b1);
    host_model_i.chip_sel_primary_b = 1'b0;
    host_model_i.beat(1'b0, 1'b1, 1'b1, 4'hf, '0);
    chk(dq_oe, 1'b1);
    host_model_i.start(1'b1, 1'b0, 1'b0, 17'h00004, 1'b0);
    repeat (3)
    begin
      host_model_i.beat(1'b0, 1'b1, 1'b1, 4'hf, '0);
      chk(dq_oe, 1'b0);
    end
  endtask : t_desel

  // Advance held off keeps the address; output enable acts without a clock
  task automatic t_hold();
    host_model_i.start(1'b0, 1'b0, 1'b1, 17'h00008, 1'b0);
    repeat (3)
    begin
      host_model_i.beat(1'b1, 1'b1, 1'b1, 4'hf, '0);
      chk(dq_out, mem[8]);
    end
    host_model_i.beat(1'b0, 1'b1, 1'b1, 4'hf, '0);
    chk(dq_out, mem[9]);
    host_model_i.out_enable_b = 1'b1;
    host_model_i.beat(1'b1, 1'b1, 1'b1, 4'hf, '0);
    chk(dq_oe, 1'b0);
    chk(dq_out, mem[9]);
    host_model_i.out_enable_b = 1'b0;
    #1;
    chk(dq_oe, 1'b1);
    host_model_i.out_enable_b = 1'b1;
    #1;
    chk(dq_oe, 1'b0);
    host_model_i.out_enable_b = 1'b0;
  endtask : t_hold

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    chk(dq_oe, 1'b0);
    t_write(17'h00004, 4, 1'b0, 1'b1, 4'hf);
    t_write(17'h00009, 4, 1'b0, 1'b1, 4'hf);
    t_read(1'b1, 17'h00005);
    t_read(1'b0, 17'h0000a);
    t_write(17'h00009, 1, 1'b1, 1'b0, 4'h6);
    t_read(1'b0, 17'h00009);
    t_desel();
    t_hold();
    stop_test();
  end
endmodule : sync_burst_sram_access_test
